// ---- hw/watchdog_map.svh ----
`ifndef WATCHDOG_MAP_SVH
`define WATCHDOG_MAP_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define WD_ADDR_W        12
`define WD_OFS_RELOAD    12'h000
`define WD_OFS_VALUE     12'h004
`define WD_OFS_CTRL      12'h008
`define WD_OFS_INTCLR    12'h00c
`define WD_OFS_RAWSTAT   12'h010
`define WD_OFS_MASKSTAT  12'h014
`define WD_OFS_STALLCFG  12'h418
`define WD_OFS_LOCK      12'hc00
`define WD_UNLOCK_KEY    32'h1acce551

// ****************************************
// Field positions and reset values
// ****************************************
`define WD_CTRL_INTERRUPT_AND_COUNT_ENABLE_BIT  0
`define WD_CTRL_RESET_OUTPUT_ENABLE_BIT  1
`define WD_STALL_BIT       8
`define WD_RELOAD_RESET    32'hffffffff
`define WD_COUNT_ONE       32'h00000001
`define WD_ZERO32          32'h00000000

`endif

// ---- hw/watchdog_pkg.sv ----
package watchdog_pkg;

  // Two-stage timeout progress, Gray coded along the usual path
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_ARMED   = 2'b01,
    ST_PENDING = 2'b11,
    ST_FIRED   = 2'b10
  } wd_state_type;

  typedef struct packed {
    logic        wrEn;
    logic        rdEn;
    logic [11:0] addr;
    logic [31:0] wdata;
  } bus_req_type;

  typedef struct packed {
    logic interrupt_and_count_enable;
    logic reset_output_enable;
    logic stallEn;
    logic locked;
  } cfg_type;

endpackage : watchdog_pkg

// ---- hw/two_stage_watchdog_timer.sv ----
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ps
`include "watchdog_map.svh"

module two_stage_watchdog_timer (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [11:0] addr,
  input  wire logic [31:0] wrData,
  input  wire logic        wrStrobe,
  input  wire logic        rdStrobe,
  input  wire logic        cpuHalted,
  output logic      [31:0] rdData,
  output logic             nmiOut,
  output logic             sysResetOut
);

  // ****************************************
  // State
  // ****************************************
  watchdog_pkg::bus_req_type  req;
  watchdog_pkg::cfg_type      cfg_ff;
  watchdog_pkg::cfg_type      nxt_cfg;
  watchdog_pkg::wd_state_type state_ff;
  watchdog_pkg::wd_state_type nxt_state;
  logic [31:0] reload_ff;
  logic [31:0] nxt_reload;
  logic [31:0] count_ff;
  logic [31:0] nxt_count;
  logic        intPend_ff;
  logic        nxt_intPend;
  logic        reset_ff;
  logic        nxt_reset;
  logic [31:0] rdData_ff;
  logic [31:0] nxt_rdData;
  logic        halted_s1_ff;
  logic        halted_s2_ff;

  logic wrReload;
  logic wrCtrl;
  logic wrClear;
  logic wrLock;
  logic wrStall;
  logic zeroHit;
  logic stalled;
  logic enableRise;

  assign req.wrEn  = wrStrobe;
  assign req.rdEn  = rdStrobe;
  assign req.addr  = addr;
  assign req.wdata = wrData;

  // ****************************************
  // Write decode
  // ****************************************
  // locked refuses config
  assign wrReload = req.wrEn && !cfg_ff.locked && (req.addr == `WD_OFS_RELOAD);
  assign wrCtrl   = req.wrEn && !cfg_ff.locked && !cfg_ff.interrupt_and_count_enable && (req.addr == `WD_OFS_CTRL);
  assign wrClear  = req.wrEn && !cfg_ff.locked && (req.addr == `WD_OFS_INTCLR);
  assign wrStall  = req.wrEn && !cfg_ff.locked && (req.addr == `WD_OFS_STALLCFG);
  assign wrLock   = req.wrEn && (req.addr == `WD_OFS_LOCK);

  // Halt comes from the core's debug logic, treated as foreign
  always_ff @(posedge clk) begin
    if (srst) begin
      halted_s1_ff <= 1'b0;
      halted_s2_ff <= 1'b0;
    end else begin
      halted_s1_ff <= cpuHalted;
      halted_s2_ff <= halted_s1_ff;
    end
  end

  assign stalled    = cfg_ff.stallEn && halted_s2_ff;
  assign enableRise = wrCtrl && wrData[`WD_CTRL_INTERRUPT_AND_COUNT_ENABLE_BIT] && !cfg_ff.interrupt_and_count_enable;
  assign zeroHit    = cfg_ff.interrupt_and_count_enable && !stalled && (count_ff == `WD_ZERO32);

  // ****************************************
  // Configuration
  // ****************************************
  always_comb begin
    nxt_cfg    = cfg_ff;
    nxt_reload = reload_ff;
    if (wrCtrl) begin
      nxt_cfg.interrupt_and_count_enable = wrData[`WD_CTRL_INTERRUPT_AND_COUNT_ENABLE_BIT];
      nxt_cfg.reset_output_enable = wrData[`WD_CTRL_RESET_OUTPUT_ENABLE_BIT];
    end
    if (wrStall) begin
      nxt_cfg.stallEn = wrData[`WD_STALL_BIT];
    end
    if (wrReload) begin
      nxt_reload = wrData;
    end
    if (wrLock) begin
      nxt_cfg.locked = (wrData != `WD_UNLOCK_KEY);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_ff    <= '0;
      reload_ff <= `WD_RELOAD_RESET;
    end else begin
      cfg_ff    <= nxt_cfg;
      reload_ff <= nxt_reload;
    end
  end

  // ****************************************
  // Counter and timeout sequence
  // ****************************************
  always_comb begin
    nxt_count   = count_ff;
    nxt_intPend = intPend_ff;
    nxt_reset   = reset_ff;
    nxt_state   = state_ff;
    case (state_ff)
      watchdog_pkg::ST_IDLE: begin
        // load copies into idle counter too
        if (wrReload) begin
          nxt_count = wrData;
        end
        if (enableRise) begin
          nxt_count = reload_ff;
          nxt_state = watchdog_pkg::ST_ARMED;
        end
      end
      watchdog_pkg::ST_ARMED, watchdog_pkg::ST_PENDING: begin
        if (zeroHit) begin
          if (intPend_ff && cfg_ff.reset_output_enable) begin
            nxt_reset = 1'b1;
            nxt_state = watchdog_pkg::ST_FIRED;
          end else begin
            nxt_state = watchdog_pkg::ST_PENDING;
          end
          nxt_count   = reload_ff;
          nxt_intPend = 1'b1;
        end else if (!stalled) begin
          nxt_count = count_ff - `WD_COUNT_ONE;
        end
        if (wrClear) begin
          nxt_count   = reload_ff;
          nxt_state   = watchdog_pkg::ST_ARMED;
          // Timeout in the clear cycle wins over the clear
          nxt_intPend = zeroHit;
        end
        if (wrReload) begin
          nxt_count = wrData;
        end
      end
      // Reset stays asserted until the system resets the block
      watchdog_pkg::ST_FIRED: begin
        nxt_reset = 1'b1;
      end
      default: begin
        nxt_state = watchdog_pkg::ST_IDLE;
      end
    endcase
    if (cfg_ff.interrupt_and_count_enable && wrReload && (wrData == `WD_ZERO32)) begin
      nxt_intPend = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      count_ff   <= `WD_RELOAD_RESET;
      intPend_ff <= 1'b0;
      reset_ff   <= 1'b0;
      state_ff   <= watchdog_pkg::ST_IDLE;
    end else begin
      count_ff   <= nxt_count;
      intPend_ff <= nxt_intPend;
      reset_ff   <= nxt_reset;
      state_ff   <= nxt_state;
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  always_comb begin
    nxt_rdData = `WD_ZERO32;
    if (req.rdEn) begin
      case (req.addr)
        `WD_OFS_RELOAD:   nxt_rdData = reload_ff;
        `WD_OFS_VALUE:    nxt_rdData = count_ff;
        `WD_OFS_CTRL: begin
          nxt_rdData[`WD_CTRL_INTERRUPT_AND_COUNT_ENABLE_BIT] = cfg_ff.interrupt_and_count_enable;
          nxt_rdData[`WD_CTRL_RESET_OUTPUT_ENABLE_BIT] = cfg_ff.reset_output_enable;
        end
        `WD_OFS_RAWSTAT:  nxt_rdData[0] = intPend_ff;
        `WD_OFS_MASKSTAT: nxt_rdData[0] = intPend_ff && cfg_ff.interrupt_and_count_enable;
        `WD_OFS_STALLCFG: nxt_rdData[`WD_STALL_BIT] = cfg_ff.stallEn;
        `WD_OFS_LOCK:     nxt_rdData[0] = cfg_ff.locked;
        default:          nxt_rdData = `WD_ZERO32;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdData_ff <= '0;
    end else begin
      rdData_ff <= nxt_rdData;
    end
  end

  assign rdData = rdData_ff;
  assign nmiOut      = intPend_ff;
  assign sysResetOut = reset_ff;

endmodule : two_stage_watchdog_timer

// ---- bench/wd_core_model.sv ----
`timescale 1ns/1ps
// ****************************************
// Processor core halt source
// ****************************************
module wd_core_model (
  input  wire logic clk,
  input  wire logic haltReq,
  output logic      cpuHalted
);
  always_ff @(posedge clk) begin
    cpuHalted <= haltReq;
  end
endmodule : wd_core_model

// ---- bench/two_stage_watchdog_timer_assertions.sv ----
`timescale 1ns/1ps
// ****************************************
// Port checker
// ****************************************
module wd_port_checker (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic [11:0] addr,
  input wire logic [31:0] wrData,
  input wire logic        wrStrobe,
  input wire logic        rdStrobe,
  input wire logic        cpuHalted,
  input wire logic [31:0] rdData,
  input wire logic        nmiOut,
  input wire logic        sysResetOut
);
  logic locked_ff, nxt_locked, interrupt_and_count_enable_ff, nxt_interrupt_and_count_enable, clrHit;
  // Shadow of lock and sticky enable, not visible at the ports
  always_comb begin
    nxt_locked = locked_ff;
    nxt_interrupt_and_count_enable  = interrupt_and_count_enable_ff;
    if (wrStrobe && addr == 12'hc00) begin
      nxt_locked = wrData != 32'h1acce551;
    end
    if (wrStrobe && addr == 12'h008 && !locked_ff && !interrupt_and_count_enable_ff) begin
      nxt_interrupt_and_count_enable = wrData[0];
    end
  end
  always_ff @(posedge clk) begin
    locked_ff <= srst ? 1'b0 : nxt_locked;
    interrupt_and_count_enable_ff  <= srst ? 1'b0 : nxt_interrupt_and_count_enable;
  end
  assign clrHit = wrStrobe && addr == 12'h00c && !locked_ff;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence pendClr;
    nmiOut ##0 clrHit;
  endsequence
  a_nmi_holds: assert property (nmiOut && !clrHit |=> nmiOut) else $error("interrupt lost");
  a_clear_drops: assert property (pendClr |=> !nmiOut) else $error("clear ignored");
  a_reset_sticks: assert property (sysResetOut |=> sysResetOut) else $error("reset dropped");
  a_reset_cause: assert property ($rose(sysResetOut) |-> $past(nmiOut)) else $error("reset early");
  a_quiet_off: assert property (!interrupt_and_count_enable_ff && !nmiOut |=> !nmiOut) else $error("interrupt while off");
  a_zero_load: assert property (interrupt_and_count_enable_ff && !locked_ff && wrStrobe && addr == 12'h000 && wrData == 32'h0
    |-> ##[1:2] nmiOut) else $error("zero load missed");
  a_ctrl_sticky: assert property (rdStrobe && addr == 12'h008 |=> rdData[0] == interrupt_and_count_enable_ff) else $error("ctrl");
  a_lock_read: assert property (rdStrobe && addr == 12'hc00 |=> rdData == {31'h0, locked_ff}) else $error("lock");
  a_clr_reads0: assert property (rdStrobe && addr == 12'h00c |=> rdData == 32'h0) else $error("clear read");
endmodule : wd_port_checker
bind two_stage_watchdog_timer wd_port_checker chk_u (.clk, .srst, .addr, .wrData, .wrStrobe, .rdStrobe,
  .cpuHalted, .rdData, .nmiOut, .sysResetOut);

// ---- bench/two_stage_watchdog_timer_tb.sv ----
`timescale 1ns/1ps
// ****************************************
// Bench
// ****************************************
module two_stage_watchdog_timer_tb;
  logic        clk, srst, wrStrobe, rdStrobe, haltReq, cpuHalted, nmiOut, sysResetOut;
  logic [11:0] addr;
  logic [31:0] wrData, rdData, v, w;
  int          fail_count = 0;
  int          check_count = 0;
  int          n;
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  wd_core_model core_u (.clk, .haltReq, .cpuHalted);
  two_stage_watchdog_timer dut_u (.clk, .srst, .addr, .wrData, .wrStrobe, .rdStrobe, .cpuHalted,
    .rdData, .nmiOut, .sysResetOut);
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Gap cycle after each strobe keeps one assignment per step
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    addr     <= a;
    wrData   <= d;
    wrStrobe <= 1'b1;
    @(posedge clk);
    wrStrobe <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    addr     <= a;
    rdStrobe <= 1'b1;
    @(posedge clk);
    rdStrobe <= 1'b0;
    #1 v = rdData;
    @(posedge clk);
  endtask : rd
  task automatic wait_sig(input logic rst);
    for (n = 0; n < 300 && (rst ? sysResetOut : nmiOut) !== 1'b1; n++) begin
      @(posedge clk);
    end
    chk({31'h0, n < 300}, 32'h1);
    if (n >= 300) begin
      end_sim();
    end
  endtask : wait_sig
  initial begin
    srst     = 1'b1;
    wrStrobe = 1'b0;
    rdStrobe = 1'b0;
    addr     = 12'h000;
    wrData   = 32'h0;
    haltReq  = 1'b0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd(12'h004);
    chk(v, 32'hffffffff);
    wr(12'h000, 32'h64);
    rd(12'h004);
    chk(v, 32'h64);
    wr(12'h008, 32'h3);
    rd(12'h004);
    w = v;
    rd(12'h004);
    chk(v, w - 32'h2);
    chk({31'h0, w <= 32'h64 && w > 32'h5a}, 32'h1);
    wr(12'h008, 32'h0);
    rd(12'h008);
    chk(v, 32'h3);
    wait_sig(1'b0);
    rd(12'h010);
    chk(v, 32'h1);
    rd(12'h014);
    chk(v, 32'h1);
    rd(12'h004);
    chk({31'h0, v > 32'h5a}, 32'h1);
    wr(12'h000, 32'h32);
    chk({31'h0, nmiOut}, 32'h1);
    wr(12'h00c, 32'h0);
    chk({31'h0, nmiOut}, 32'h0);
    wait_sig(1'b0);
    chk({31'h0, sysResetOut}, 32'h0);
    wait_sig(1'b1);
    $display("test timeouts done");
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    wr(12'hc00, 32'h0);
    wr(12'h000, 32'h5);
    rd(12'h000);
    chk(v, 32'hffffffff);
    rd(12'hc00);
    chk(v, 32'h1);
    wr(12'hc00, 32'h1acce551);
    rd(12'hc00);
    chk(v, 32'h0);
    rd(12'h00c);
    chk(v, 32'h0);
    rd(12'h020);
    chk(v, 32'h0);
    $display("test lock done");
    wr(12'h000, 32'h64);
    wr(12'h418, 32'h100);
    wr(12'h008, 32'h1);
    haltReq <= 1'b1;
    repeat (4) @(posedge clk);
    rd(12'h004);
    w = v;
    rd(12'h004);
    chk(v, w);
    haltReq <= 1'b0;
    repeat (4) @(posedge clk);
    wr(12'h000, 32'h0);
    @(posedge clk);
    chk({31'h0, nmiOut}, 32'h1);
    repeat (3) @(posedge clk);
    chk({31'h0, sysResetOut}, 32'h0);
    $display("test stall done");
    end_sim();
  end
endmodule : two_stage_watchdog_timer_tb
